// [core/diff_manchester_mac_framer.v]
`timescale 1ns/1ps
`default_nettype none
`include "mac_framer_defines.vh"

module diff_manchester_mac_framer (
	input wire clock,
	input wire srst,
	input wire [9:0] bitTerm,
	input wire [4:0] preambleLen,
	input wire txEnableUse,
	input wire collisionUse,
	input wire dmaPolarity,
	input wire txWrEn,
	input wire txWrPri,
	input wire [3:0] txWrAddr,
	input wire [7:0] txWrData,
	input wire txSend,
	input wire txSendPri,
	input wire [4:0] txSendLen,
	output reg txLine,
	output reg txEnable,
	input wire collisionSenseN,
	input wire rxLine,
	output wire [7:0] rxData,
	output wire rxValid,
	input wire rxReady,
	output reg dmaTrigger,
	output reg txPriFull,
	output reg txNonFull,
	output reg [5:0] backlog,
	output reg collisionFlag,
	output reg irqFrameEnd,
	output reg irqRxError,
	output reg irqBacklog,
	output reg irqCollision,
	output reg irqTxBegin,
	output reg irqTxDone
);

localparam TX_IDLE = 3'h0;
localparam TX_PRE = 3'h1;
localparam TX_SYNC = 3'h2;
localparam TX_DATA = 3'h3;
localparam TX_CRC = 3'h4;
localparam TX_VIOL = 3'h5;

localparam RX_HUNT = 2'h0;
localparam RX_PRE = 2'h1;
localparam RX_DATA = 2'h2;

function [15:0] crcStep;
	input [15:0] c;
	input b;
	begin
		crcStep = {c[14:0], 1'b0} ^ ((c[15] ^ b) ? `CRC_POLY : 16'h0000);
	end
endfunction

// ==================================================
// bit timing
wire [31:0] defTerm = `BIT_CYCLES;
wire [31:0] cdCycles = `CD_CYCLES;
wire [9:0] term = (bitTerm == 10'h000) ? defTerm[9:0] : bitTerm; // RL1 RL23
wire [9:0] half = {1'b0, term[9:1]};
wire [9:0] termLast = term - 10'h001;
// short settings are stretched rather than refused
wire [4:0] preLast = (preambleLen < `PREAMBLE_MIN) ? (`PREAMBLE_MIN - 5'h01) : (preambleLen - 5'h01); // RL5

// ==================================================
// transmit buffers
reg [7:0] txMem [0:31];
reg [4:0] priLen_r;
reg [4:0] nonLen_r;
wire [4:0] lenEff = ((txSendLen == 5'h00) || (txSendLen > `BUF_BYTES)) ? `BUF_BYTES : txSendLen;

always @(posedge clock) begin
	if (txWrEn)
		txMem[{txWrPri, txWrAddr}] <= txWrData; // RL14
end

// ==================================================
// transmit encoder
reg [2:0] txState_r;
reg [9:0] txCnt_r;
reg [4:0] txBits_r;
reg [4:0] txIdx_r;
reg [7:0] txShift_r;
reg [15:0] txCrc_r;
reg txBit_r;
reg txSel_r;
wire txOn = (txState_r != TX_IDLE);
wire cellStart = (txCnt_r == 10'h000);
wire cellMid = (txCnt_r == half);
wire cellEnd = (txCnt_r == termLast);
wire [7:0] txByte = txMem[{txSel_r, txIdx_r[3:0]}];
wire [4:0] curLen = txSel_r ? priLen_r : nonLen_r;
wire [15:0] txCrcN = crcStep(txCrc_r, txBit_r);
wire collChk = txOn && cellEnd && (txBits_r == 5'h00) && ((txState_r == TX_PRE) || (txState_r == TX_VIOL));

always @(posedge clock) begin
	if (srst) begin
		txState_r <= TX_IDLE;
		txCnt_r <= 10'h000;
		txBits_r <= 5'h00;
		txIdx_r <= 5'h00;
		txShift_r <= 8'h00;
		txCrc_r <= `CRC_INIT;
		txBit_r <= 1'b1;
		txSel_r <= 1'b0;
		txLine <= 1'b0;
		txEnable <= 1'b0;
		txPriFull <= 1'b0;
		txNonFull <= 1'b0;
		priLen_r <= `BUF_BYTES;
		nonLen_r <= `BUF_BYTES;
		irqTxBegin <= 1'b0;
		irqTxDone <= 1'b0;
	end else begin
		irqTxBegin <= 1'b0;
		irqTxDone <= 1'b0;
		if (!txOn) begin
			if (txPriFull || txNonFull) begin
				// priority traffic always goes first
				txSel_r <= txPriFull; // RL14
				txState_r <= TX_PRE;
				txCnt_r <= 10'h000;
				txBit_r <= 1'b1;
				txBits_r <= preLast; // RL5
				txCrc_r <= `CRC_INIT;
				txEnable <= txEnableUse; // RL16 RL19
				irqTxBegin <= 1'b1;
			end
		end else begin
			txCnt_r <= cellEnd ? 10'h000 : (txCnt_r + 10'h001);
			// closing boundary of the last check bit is the only edge in the violation
			if ((cellStart && ((txState_r != TX_VIOL) || (txBits_r == `VIOL_LAST))) || (cellMid && !txBit_r))
				txLine <= ~txLine; // RL2 RL3
			if (cellEnd) begin
				case (txState_r)
					TX_PRE: begin
						if (txBits_r == 5'h00) begin
							txState_r <= TX_SYNC;
							txBit_r <= 1'b0; // RL6
							txIdx_r <= 5'h00;
						end else begin
							txBits_r <= txBits_r - 5'h01;
						end
					end
					TX_SYNC: begin
						txState_r <= TX_DATA;
						txBit_r <= txByte[7];
						txShift_r <= {txByte[6:0], 1'b0};
						txBits_r <= `BYTE_LAST;
						txIdx_r <= txIdx_r + 5'h01;
					end
					TX_DATA: begin
						txCrc_r <= txCrcN; // RL8 RL24
						if (txBits_r != 5'h00) begin
							txBit_r <= txShift_r[7];
							txShift_r <= {txShift_r[6:0], 1'b0};
							txBits_r <= txBits_r - 5'h01;
						end else if (txIdx_r == curLen) begin
							txState_r <= TX_CRC;
							txBit_r <= txCrcN[15]; // RL8
							txCrc_r <= {txCrcN[14:0], 1'b0};
							txBits_r <= `CRC_LAST;
						end else begin
							txBit_r <= txByte[7];
							txShift_r <= {txByte[6:0], 1'b0};
							txBits_r <= `BYTE_LAST;
							txIdx_r <= txIdx_r + 5'h01;
						end
					end
					TX_CRC: begin
						if (txBits_r == 5'h00) begin
							txState_r <= TX_VIOL;
							txBits_r <= `VIOL_LAST; // RL7
							txBit_r <= 1'b1;
						end else begin
							txBit_r <= txCrc_r[15];
							txCrc_r <= {txCrc_r[14:0], 1'b0};
							txBits_r <= txBits_r - 5'h01;
						end
					end
					TX_VIOL: begin
						if (txBits_r == 5'h00) begin
							txState_r <= TX_IDLE;
							txEnable <= 1'b0; // RL19
							irqTxDone <= 1'b1;
							if (txSel_r)
								txPriFull <= 1'b0;
							else
								txNonFull <= 1'b0;
						end else begin
							txBits_r <= txBits_r - 5'h01;
						end
					end
					default: begin
						txState_r <= TX_IDLE;
					end
				endcase
			end
		end
		// a new send request wins over the clear at packet end
		if (txSend) begin
			if (txSendPri) begin
				txPriFull <= 1'b1;
				priLen_r <= lenEff;
			end else begin
				txNonFull <= 1'b1;
				nonLen_r <= lenEff;
			end
		end
	end
end

// ==================================================
// collision sense
reg cdS1_r;
reg cdS2_r;
reg [2:0] cdLow_r;
reg collSeen_r;
wire cdHit = collisionUse && txOn && !cdS2_r && (cdLow_r == (cdCycles[2:0] - 3'h1));

always @(posedge clock) begin
	if (srst) begin
		cdS1_r <= 1'b1;
		cdS2_r <= 1'b1;
		cdLow_r <= 3'h0;
		collSeen_r <= 1'b0;
		collisionFlag <= 1'b0;
		irqCollision <= 1'b0;
	end else begin
		cdS1_r <= collisionSenseN;
		cdS2_r <= cdS1_r;
		if (!cdS2_r && txOn && collisionUse) begin
			if (cdLow_r != cdCycles[2:0])
				cdLow_r <= cdLow_r + 3'h1; // RL20
		end else begin
			cdLow_r <= 3'h0;
		end
		collSeen_r <= (txOn & collSeen_r) | cdHit; // RL17 RL20
		irqCollision <= collChk && collSeen_r; // RL20
		if (collChk && collSeen_r)
			collisionFlag <= 1'b1;
		else if (irqTxBegin)
			collisionFlag <= 1'b0;
	end
end

// ==================================================
// receive decoder
reg rxS1_r;
reg rxS2_r;
reg rxS3_r;
reg edgePend_r;
reg edgeLvl_r;
reg [1:0] rxState_r;
reg [9:0] rxCnt_r;
reg rxMid_r;
reg [2:0] rxBitCnt_r;
reg [7:0] rxShift_r;
reg [15:0] rxCrc_r;
reg [7:0] hold0_r;
reg [7:0] hold1_r;
reg [1:0] holdCnt_r;
reg rxBad_r;
reg pushValid_r;
reg [7:0] pushData_r;
reg [3:0] rxByteCnt_r;
reg rxGood_r;
wire skidReady;
wire edgeOk = edgePend_r && (rxS2_r == edgeLvl_r); // RL22
wire inHalf = (rxCnt_r >= (half - `RX_JITTER)) && (rxCnt_r <= (half + `RX_JITTER)); // RL21
wire inFull = (rxCnt_r >= (term - `RX_JITTER)); // RL21
wire rxTimeout = (rxCnt_r > (term + `RX_JITTER)); // RL21
wire rxBit = ~rxMid_r; // RL3
wire [7:0] newByte = {rxShift_r[6:0], rxBit};

always @(posedge clock) begin
	if (srst) begin
		rxS1_r <= 1'b0;
		rxS2_r <= 1'b0;
		rxS3_r <= 1'b0;
		edgePend_r <= 1'b0;
		edgeLvl_r <= 1'b0;
		rxState_r <= RX_HUNT;
		rxCnt_r <= 10'h000;
		rxMid_r <= 1'b0;
		rxBitCnt_r <= 3'h0;
		rxShift_r <= 8'h00;
		rxCrc_r <= `CRC_INIT;
		hold0_r <= 8'h00;
		hold1_r <= 8'h00;
		holdCnt_r <= 2'h0;
		rxBad_r <= 1'b0;
		pushValid_r <= 1'b0;
		pushData_r <= 8'h00;
		rxByteCnt_r <= 4'h0;
		rxGood_r <= 1'b0;
		dmaTrigger <= 1'b0;
		irqFrameEnd <= 1'b0;
		irqRxError <= 1'b0;
	end else begin
		rxS1_r <= rxLine;
		rxS2_r <= rxS1_r;
		rxS3_r <= rxS2_r;
		// either edge direction counts, so polarity is irrelevant
		// the return edge of a dropped narrow pulse is noise as well
		edgePend_r <= (rxS2_r ^ rxS3_r) & ~(edgePend_r & ~edgeOk); // RL4 RL22
		edgeLvl_r <= rxS2_r;
		pushValid_r <= 1'b0;
		rxGood_r <= 1'b0;
		irqFrameEnd <= 1'b0;
		irqRxError <= 1'b0;
		dmaTrigger <= dmaPolarity;
		if (pushValid_r) begin
			if (skidReady) begin
				rxByteCnt_r <= rxByteCnt_r + 4'h1;
				if (rxByteCnt_r == 4'hf)
					dmaTrigger <= ~dmaPolarity; // RL10 RL15
			end else begin
				rxBad_r <= 1'b1;
			end
		end
		if (rxState_r == RX_HUNT) begin
			if (edgeOk) begin
				rxState_r <= RX_PRE;
				rxCnt_r <= 10'h001;
				rxMid_r <= 1'b0;
			end
		end else if (rxTimeout) begin
			rxState_r <= RX_HUNT;
			irqFrameEnd <= 1'b1; // RL11
			if (rxState_r == RX_DATA) begin
				if (rxBad_r || (rxBitCnt_r != 3'h0) || (rxCrc_r != 16'h0000) || (holdCnt_r != 2'h2))
					irqRxError <= 1'b1; // RL9 RL12
				else
					rxGood_r <= 1'b1;
			end
		end else if (edgeOk && inFull) begin
			// edge is seen one clock late, so the new cell is already one clock old
			rxCnt_r <= 10'h001;
			rxMid_r <= 1'b0;
			if (rxState_r == RX_PRE) begin
				if (!rxBit) begin
					rxState_r <= RX_DATA; // RL6
					rxBitCnt_r <= 3'h0;
					rxCrc_r <= `CRC_INIT;
					holdCnt_r <= 2'h0;
					rxBad_r <= 1'b0;
					rxByteCnt_r <= 4'h0;
				end
			end else begin
				rxShift_r <= newByte;
				rxCrc_r <= crcStep(rxCrc_r, rxBit); // RL9 RL24
				rxBitCnt_r <= rxBitCnt_r + 3'h1;
				if (rxBitCnt_r == 3'h7) begin
					// last two bytes held back: they are the check word
					if (holdCnt_r == 2'h2) begin
						pushValid_r <= 1'b1; // RL18
						pushData_r <= hold0_r;
						hold0_r <= hold1_r;
						hold1_r <= newByte;
					end else if (holdCnt_r == 2'h0) begin
						hold0_r <= newByte;
						holdCnt_r <= 2'h1;
					end else begin
						hold1_r <= newByte;
						holdCnt_r <= 2'h2;
					end
				end
			end
		end else begin
			if (edgeOk && inHalf)
				rxMid_r <= 1'b1; // RL3 RL21
			rxCnt_r <= rxCnt_r + 10'h001;
		end
	end
end

// ==================================================
// receive buffer toward host
word_skid_buffer rxBuffer (
	.clock(clock),
	.srst(srst),
	.inData(pushData_r),
	.inValid(pushValid_r),
	.inReady(skidReady),
	.outData(rxData),
	.outValid(rxValid),
	.outReady(rxReady)
);

// ==================================================
// backlog
always @(posedge clock) begin
	if (srst) begin
		backlog <= 6'h00;
		irqBacklog <= 1'b0;
	end else begin
		irqBacklog <= 1'b0;
		if (rxGood_r) begin
			if (backlog == `BACKLOG_MAX)
				irqBacklog <= 1'b1; // RL13
			else
				backlog <= backlog + 6'h01; // RL13
		end else if (irqTxDone && (backlog != 6'h00)) begin
			backlog <= backlog - 6'h01;
		end
	end
end

endmodule

`default_nettype wire

// [core/mac_framer_defines.vh]
// Summary of operation
// RL1: line runs at 78.125 kbit/s, one bit period is 12.8 us.
// RL2: transmitter toggles the line at the start of every bit cell.
// RL3: a midpoint toggle means zero, no midpoint toggle means one.
// RL4: receiver decodes transitions only, so line polarity does not matter.
// RL5: packet starts with a selectable preamble of ones, never below six bits.
// RL6: preamble ends with one zero; first byte starts on the next bit.
// RL7: after the last check bit the line stays transitionless for three bit periods.
// RL8: transmitter computes a check word and appends it to every packet.
// RL9: receiver checks the trailing check word and reports an error on mismatch.
// RL10: received bytes fill a 16-byte buffer; a full buffer raises a DMA request.
// RL11: end-of-frame code violation raises an interrupt for DMA re-initialisation.
// RL12: any receive error raises an interrupt.
// RL13: device keeps the backlog value and interrupts when it overflows.
// RL14: transmit side holds separate priority and non-priority buffers.
// RL15: a dedicated output carries the DMA transfer trigger.
// RL16: optional transmit-enable output that can be switched off.
// RL17: optional collision input that can be switched off.
// RL18: receiver strips framing and passes only the data unit bytes.
// RL19: transmit enable rises before the packet and falls after the violation.
// RL20: collision input low for 200 ns while sending sets a flag and interrupts.
// RL21: acceptance windows near T/2 and T; no transition ends the packet.
// RL22: a transition already reversed when serviced is dropped as noise.
// RL23: bit timing comes from a clock counter with programmable terminal count.
// RL24: check word is the 16-bit polynomial over all preceding packet bytes.
`ifndef MAC_FRAMER_DEFINES_VH
`define MAC_FRAMER_DEFINES_VH

// ==================================================
// timing
`define CLK_PERIOD_NS 50
`define BIT_PERIOD_NS 12800
`define BIT_CYCLES (`BIT_PERIOD_NS / `CLK_PERIOD_NS)
`define CD_MIN_NS 200
`define CD_CYCLES ((`CD_MIN_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define RX_JITTER 10'h020

// ==================================================
// framing
`define PREAMBLE_MIN 5'h06
`define VIOL_LAST 5'h02
`define BYTE_LAST 5'h07
`define CRC_LAST 5'h0f
`define BUF_BYTES 5'h10
`define CRC_POLY 16'h1021
`define CRC_INIT 16'hffff
`define BACKLOG_MAX 6'h3f

`endif

// [core/word_skid_buffer.v]
`timescale 1ns/1ps
`default_nettype none

// two-entry buffer: head and tail flops, outputs straight from flops
module word_skid_buffer (
	input wire clock,
	input wire srst,
	input wire [7:0] inData,
	input wire inValid,
	output reg inReady,
	output reg [7:0] outData,
	output reg outValid,
	input wire outReady
);

reg [7:0] tail_r;
reg [1:0] cnt_r;
reg [1:0] cnt_nxt;
wire push = inValid & inReady;
wire pop = outValid & outReady;

always @* begin
	cnt_nxt = cnt_r;
	if (push && !pop)
		cnt_nxt = cnt_r + 2'h1;
	else if (pop && !push)
		cnt_nxt = cnt_r - 2'h1;
end

always @(posedge clock) begin
	if (srst) begin
		cnt_r <= 2'h0;
		outData <= 8'h00;
		tail_r <= 8'h00;
		outValid <= 1'b0;
		inReady <= 1'b1;
	end else begin
		cnt_r <= cnt_nxt;
		outValid <= (cnt_nxt != 2'h0);
		inReady <= (cnt_nxt != 2'h2);
		if (pop) begin
			if (cnt_r == 2'h2) begin
				outData <= tail_r;
				if (push)
					tail_r <= inData;
			end else if (push) begin
				outData <= inData;
			end
		end else if (push) begin
			if (cnt_r == 2'h0)
				outData <= inData;
			else
				tail_r <= inData;
		end
	end
end

endmodule

`default_nettype wire

// [testbench/line_partner.sv]
`timescale 1ns/1ps
`default_nettype none
// ==========
// transceiver that echoes the line
module line_partner (
	input wire logic txLine,
	input wire logic invert,
	input wire logic glitch,
	input wire logic collide,
	output logic rxLine,
	output logic collisionSenseN
);
	// echo keeps cell code, inversion models swapped wires
	assign rxLine = txLine ^ invert ^ glitch;
	assign collisionSenseN = !collide;
endmodule
`default_nettype wire

// [testbench/framer_chk.sv]
`timescale 1ns/1ps
`default_nettype none
// ==========
// port checker
module framer_chk (
	input wire logic clock,
	input wire logic srst,
	input wire logic [9:0] bitTerm,
	input wire logic txEnableUse,
	input wire logic collisionUse,
	input wire logic dmaPolarity,
	input wire logic txSend,
	input wire logic txLine,
	input wire logic txEnable,
	input wire logic [7:0] rxData,
	input wire logic rxValid,
	input wire logic rxReady,
	input wire logic dmaTrigger,
	input wire logic txPriFull,
	input wire logic txNonFull,
	input wire logic [5:0] backlog,
	input wire logic collisionFlag,
	input wire logic irqFrameEnd,
	input wire logic irqBacklog,
	input wire logic irqCollision,
	input wire logic irqTxBegin,
	input wire logic irqTxDone
);
	default clocking @(posedge clock); endclocking
	default disable iff (srst);
	logic lastTx;
	logic [15:0] gap;
	logic [15:0] term;
	assign term = (bitTerm == 10'h000) ? 16'h0100 : {6'h00, bitTerm};
	// cycles since previous line edge, saturating
	always @(posedge clock) begin
		lastTx <= txLine;
		if (srst)
			gap <= 16'hffff;
		else if (txLine != lastTx)
			gap <= 16'h0001;
		else if (gap != 16'hffff)
			gap <= gap + 16'h0001;
	end
	sequence sIdleSend;
		txSend && !txPriFull && !txNonFull;
	endsequence
	sequence sStart;
		##1 (txPriFull || txNonFull) ##1 irqTxBegin ##1 (txLine != lastTx);
	endsequence
	chk_send_starts: assert property (sIdleSend |-> sStart)
		else $error("send did not start a packet");
	chk_txen_begin: assert property (irqTxBegin && txEnableUse |-> txEnable)
		else $error("enable low at packet start");
	chk_txen_unused: assert property (irqTxBegin && !txEnableUse |-> !txEnable)
		else $error("enable driven while unused");
	chk_txen_end: assert property ($fell(txEnable) |-> irqTxDone)
		else $error("enable fell outside packet end");
	chk_cell_width: assert property ((txLine != lastTx) && gap < 2 * term |-> gap == term || gap == term / 2)
		else $error("line edge off the cell grid");
	chk_violation_len: assert property (irqTxDone |-> gap + 4 >= 3 * term && gap <= 3 * term + 4)
		else $error("end violation not three cells");
	chk_dma_pulse: assert property (dmaTrigger != dmaPolarity |=> dmaTrigger == dmaPolarity)
		else $error("dma trigger wider than one cycle");
	chk_end_pulse: assert property (irqFrameEnd |=> !irqFrameEnd)
		else $error("frame end pulse too long");
	chk_rx_hold: assert property (rxValid && !rxReady |=> rxValid && $stable(rxData))
		else $error("rx byte dropped while stalled");
	chk_col_flag: assert property (irqCollision |=> collisionFlag)
		else $error("collision flag not set");
	chk_col_off: assert property (!collisionUse |-> !irqCollision)
		else $error("collision reported while off");
	chk_backlog_top: assert property (irqBacklog |-> backlog == 6'h3f)
		else $error("backlog irq below top");
endmodule
bind diff_manchester_mac_framer framer_chk u_chk (.clock, .srst, .bitTerm, .txEnableUse, .collisionUse,
	.dmaPolarity, .txSend, .txLine, .txEnable, .rxData, .rxValid, .rxReady, .dmaTrigger, .txPriFull,
	.txNonFull, .backlog, .collisionFlag, .irqFrameEnd, .irqBacklog, .irqCollision, .irqTxBegin, .irqTxDone);
`default_nettype wire

// [testbench/tb_top.sv]
`timescale 1ns/1ps
`default_nettype none
`define CHECK(nm, e, a) begin checksDone++; if ((a) !== (e)) begin nErrors++; \
	$display("ERROR %s expected %0h seen %0h", nm, e, a); end end
module tb_top;
	logic clock = 0;
	logic srst = 1;
	logic [9:0] bitTerm = 10'h0a0;
	logic [4:0] preambleLen = 5'h06;
	logic txEnableUse = 1;
	logic collisionUse = 0;
	logic dmaPolarity = 1;
	logic txWrEn = 0;
	logic txWrPri = 0;
	logic [3:0] txWrAddr = 4'h0;
	logic [7:0] txWrData = 8'h00;
	logic txSend = 0;
	logic txSendPri = 0;
	logic [4:0] txSendLen = 5'h00;
	logic rxReady = 1;
	logic invert = 0;
	logic glitch = 0;
	logic collide = 0;
	logic txLine, txEnable, collisionSenseN, rxLine, rxValid, dmaTrigger, txPriFull, txNonFull;
	logic collisionFlag, irqFrameEnd, irqRxError, irqBacklog, irqCollision, irqTxBegin, irqTxDone;
	logic [7:0] rxData;
	logic [5:0] backlog;
	logic [5:0] blAtDone = 6'h00;
	int nErrors = 0;
	int checksDone = 0;
	int dmaCnt, endCnt, errCnt, colCnt, doneCnt, enCnt;
	logic [7:0] got[$];
	logic [7:0] exp[$];
	always #25 clock = ~clock;
	diff_manchester_mac_framer dut (.clock, .srst, .bitTerm, .preambleLen, .txEnableUse, .collisionUse,
		.dmaPolarity, .txWrEn, .txWrPri, .txWrAddr, .txWrData, .txSend, .txSendPri, .txSendLen, .txLine,
		.txEnable, .collisionSenseN, .rxLine, .rxData, .rxValid, .rxReady, .dmaTrigger, .txPriFull,
		.txNonFull, .backlog, .collisionFlag, .irqFrameEnd, .irqRxError, .irqBacklog, .irqCollision,
		.irqTxBegin, .irqTxDone);
	line_partner u_line (.txLine, .invert, .glitch, .collide, .rxLine, .collisionSenseN);
	// ==========
	// monitor
	always @(posedge clock) begin
		if (rxValid === 1'b1 && rxReady) got.push_back(rxData);
		dmaCnt += (dmaTrigger !== dmaPolarity);
		endCnt += (irqFrameEnd === 1'b1);
		errCnt += (irqRxError === 1'b1);
		colCnt += (irqCollision === 1'b1);
		doneCnt += (irqTxDone === 1'b1);
		enCnt += (txEnable === 1'b1);
		// backlog as it stands before the end of sending takes one off
		if (irqTxDone === 1'b1) blAtDone = backlog;
	end
	// ==========
	// helpers
	task automatic step(input int n);
		repeat (n) @(posedge clock);
		#1;
	endtask
	task automatic clr();
		{dmaCnt, endCnt, errCnt, colCnt, doneCnt, enCnt} = '0;
		got.delete();
	endtask
	task automatic loadSend(input logic pri, input int n, input logic [7:0] base);
		exp.delete();
		for (int i = 0; i < n; i++) begin
			txWrEn = 1;
			txWrPri = pri;
			txWrAddr = i[3:0];
			txWrData = base + 8'(i * 29);
			exp.push_back(txWrData);
			step(1);
		end
		txWrEn = 0;
		txSend = 1;
		txSendPri = pri;
		txSendLen = n[4:0];
		step(1);
		txSend = 0;
	endtask
	task automatic waitTx();
		int k;
		k = 0;
		while (doneCnt == 0 && k < 30000) begin
			step(1);
			k++;
		end
		`CHECK("tx done", 1, doneCnt)
		step(400);
	endtask
	task automatic cmpFrame();
		`CHECK("rx count", exp.size(), got.size())
		foreach (exp[i]) if (i < got.size()) `CHECK("rx byte", exp[i], got[i])
	endtask
	// ==========
	// scenarios
	task automatic testFull();
		clr();
		loadSend(1, 16, 8'h5a);
		waitTx();
		cmpFrame();
		`CHECK("dma pulses", 1, dmaCnt)
		`CHECK("frame end", 1, endCnt)
		`CHECK("rx error", 0, errCnt)
		`CHECK("enable seen", 1, enCnt > 0)
		`CHECK("backlog", 6'h01, blAtDone)
		$display("test full frame done");
	endtask
	task automatic testInvert();
		invert = 1;
		preambleLen = 5'h02;
		step(1000);
		clr();
		rxReady = 0;
		loadSend(0, 3, 8'hc3);
		step(1500);
		rxReady = 1;
		// narrow pulse in the half window of a one bit: taken as an edge it would corrupt byte two
		step(1122);
		glitch = 1;
		step(1);
		glitch = 0;
		waitTx();
		cmpFrame();
		`CHECK("rx error", 0, errCnt)
		`CHECK("frame end", 1, endCnt)
		preambleLen = 5'h06;
		$display("test inverted line done");
	endtask
	task automatic testOverflow();
		clr();
		rxReady = 0;
		loadSend(1, 6, 8'h81);
		waitTx();
		`CHECK("rx error", 1, errCnt)
		`CHECK("backlog", 6'h00, blAtDone)
		rxReady = 1;
		step(10);
		`CHECK("kept bytes", 2, got.size())
		$display("test overflow done");
	endtask
	task automatic testCollide();
		clr();
		collisionUse = 1;
		txEnableUse = 0;
		// zero selects the default bit period
		bitTerm = 10'h000;
		loadSend(0, 2, 8'h3c);
		step(200);
		collide = 1;
		step(8);
		collide = 0;
		waitTx();
		cmpFrame();
		`CHECK("collision irq", 1, colCnt > 0)
		`CHECK("collision flag", 1'b1, collisionFlag)
		`CHECK("enable unused", 0, enCnt)
		collisionUse = 0;
		txEnableUse = 1;
		bitTerm = 10'h0a0;
		$display("test collision done");
	endtask
	task automatic finishTest();
		$display("checks %0d errors %0d", checksDone, nErrors);
		if (nErrors == 0 && checksDone > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask
	initial begin
		step(20);
		srst = 0;
		`CHECK("reset state", 9'h000, {txLine, txEnable, rxValid, backlog})
		// dma trigger leaves its reset level one edge after release; do not count that
		step(2);
		testFull();
		testInvert();
		testOverflow();
		testCollide();
		finishTest();
	end
	// run needs about 58000 cycles
	initial begin
		#(90000 * 50);
		nErrors++;
		finishTest();
	end
endmodule
`default_nettype wire
